// ### sss_pkg.sv
package sss_pkg;

    localparam int DATA_W = 8;
    localparam int CNT_W  = 4;

    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [CNT_W-1:0]  CNT_RST  = 4'h0;
    localparam logic [CNT_W-1:0]  CNT_MAX  = 4'hF;
    localparam logic [CNT_W-1:0]  CNT_ONE  = 4'h1;
    localparam logic [CNT_W-1:0]  CNT_TWO  = 4'h2;
    localparam int                MSB      = DATA_W - 1;

    // Highest serial clock rate, as a divisor of sys_clk.
    localparam int TWO_WIRE_DIV     = 16;
    localparam int THREE_MASTER_DIV = 2;
    localparam int THREE_SLAVE_DIV  = 4;
    // Cycles from a link edge until it is seen in the sys_clk domain.
    localparam int SYNC_LAT         = 3;

    typedef enum logic [1:0] {
        WM_OFF,
        WM_THREE,
        WM_TWO
    } sss_wire_t;

    typedef enum logic [1:0] {
        CS_SOFT,
        CS_TIMER,
        CS_EXT
    } sss_src_t;

    typedef struct packed {
        sss_wire_t wire_mode;
        sss_src_t  clk_src;
        logic      clock_edge_select;
        logic      clk_master;
        logic      hold_start;
        logic      hold_ovf;
    } sss_cfg_t;

    typedef struct packed {
        logic start;
        logic ovf;
    } sss_evt_t;

endpackage : sss_pkg

// ### sss_sync.sv
`timescale 1ns/1ns
module sss_sync (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta     <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule : sss_sync

// ### sss_edge_cross.sv
`timescale 1ns/1ns
module sss_edge_cross #(
    parameter bit FALLING = 1'b0
) (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic link_clk,
    input  wire logic data_in,
    output logic      edge_pulse,
    output logic      edge_bit
);

    logic tgl;
    logic cap;
    logic cap_meta;
    logic tgl_meta;
    logic tgl_sync;
    logic tgl_prev;

    // Bit and toggle are taken on the same link edge; the bit then stands
    // a full link period, far longer than the toggle needs to cross.
    if (FALLING) begin : g_neg
        always_ff @(negedge link_clk or posedge sys_rst) begin
            if (sys_rst) begin
                tgl <= 1'b0;
                cap <= 1'b0;
            end else begin
                tgl <= ~tgl;
                cap <= data_in;
            end
        end
    end else begin : g_pos
        always_ff @(posedge link_clk or posedge sys_rst) begin
            if (sys_rst) begin
                tgl <= 1'b0;
                cap <= 1'b0;
            end else begin
                tgl <= ~tgl;
                cap <= data_in;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tgl_meta   <= 1'b0;
            tgl_sync   <= 1'b0;
            tgl_prev   <= 1'b0;
            edge_pulse <= 1'b0;
            cap_meta   <= 1'b0;
            edge_bit   <= 1'b0;
        end else begin
            tgl_meta   <= tgl;
            tgl_sync   <= tgl_meta;
            tgl_prev   <= tgl_sync;
            edge_pulse <= tgl_sync ^ tgl_prev;
            cap_meta   <= cap;
            edge_bit   <= cap_meta;
        end
    end

endmodule : sss_edge_cross

// ### sss_serial_shift_unit.sv
`timescale 1ns/1ns
module sss_serial_shift_unit (
    input  wire logic                          sys_clk,
    input  wire logic                          sys_rst,
    input  wire logic                          shift_clock_pin,
    input  wire logic                          serial_data_in,
    input  wire sss_pkg::sss_cfg_t             cfg,
    input  wire logic                          data_wr,
    input  wire logic [sss_pkg::DATA_W-1:0]    data_wdata,
    input  wire logic                          cnt_wr,
    input  wire logic [sss_pkg::CNT_W-1:0]     cnt_wdata,
    input  wire logic                          soft_strobe,
    input  wire logic                          timer_ovf,
    input  wire logic                          clock_toggle_strobe,
    input  wire sss_pkg::sss_evt_t             flag_clr,
    input  wire sss_pkg::sss_evt_t             irq_en,
    output logic [sss_pkg::DATA_W-1:0]         shift_data_register,
    output logic [sss_pkg::CNT_W-1:0]          count,
    output sss_pkg::sss_evt_t                  flags,
    output sss_pkg::sss_evt_t                  irq,
    output logic                               wake_idle,
    output logic                               wake_deep,
    output logic                               data_out_pin,
    output logic                               sda_out,
    output logic                               sda_oe,
    output logic                               scl_out,
    output logic                               scl_oe
);

    ////////////////////////////////////////////////////////////////////////

    function automatic logic [sss_pkg::CNT_W:0] cnt_add(
        input logic [sss_pkg::CNT_W-1:0] base,
        input logic [sss_pkg::CNT_W-1:0] step
    );
        cnt_add = {1'b0, base} + {1'b0, step};
    endfunction : cnt_add

    logic di_sync;
    logic scl_sync;
    logic sda_prev;
    logic rise_pulse;
    logic rise_bit;
    logic fall_pulse;
    logic fall_bit;
    logic ext_mode;
    logic two_wire;
    logic samp_evt;
    logic samp_bit;
    logic out_evt;
    logic int_evt;
    logic start_det;
    logic ovf_evt;
    logic out_latch;
    logic clk_level;
    logic hold_low;
    logic [sss_pkg::CNT_W-1:0] step;
    logic [sss_pkg::CNT_W:0]   next_count;

    // Pin levels cross two flip-flops before the start detector and internal shifting look at them.
    sss_sync u_di_sync (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .async_in (serial_data_in),
        .sync_out (di_sync)
    );

    sss_sync u_scl_sync (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .async_in (shift_clock_pin),
        .sync_out (scl_sync)
    );

    // Each link edge samples the data pin on the link clock and crosses by
    // toggle; three sys_clk cycles of latency fit within the fastest
    // slave clock of a quarter and the two-wire clock of a sixteenth.
    sss_edge_cross #(.FALLING(1'b0)) u_rise (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .link_clk   (shift_clock_pin),
        .data_in    (serial_data_in),
        .edge_pulse (rise_pulse),
        .edge_bit   (rise_bit)
    );

    sss_edge_cross #(.FALLING(1'b1)) u_fall (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .link_clk   (shift_clock_pin),
        .data_in    (serial_data_in),
        .edge_pulse (fall_pulse),
        .edge_bit   (fall_bit)
    );

    ////////////////////////////////////////////////////////////////////////

    assign ext_mode = (cfg.clk_src == sss_pkg::CS_EXT);
    assign two_wire = (cfg.wire_mode == sss_pkg::WM_TWO);

    assign samp_evt = ext_mode &&
        (cfg.clock_edge_select ? fall_pulse : rise_pulse);
    assign samp_bit = cfg.clock_edge_select ? fall_bit : rise_bit;
    assign out_evt  = ext_mode &&
        (cfg.clock_edge_select ? rise_pulse : fall_pulse);

    assign int_evt = ((cfg.clk_src == sss_pkg::CS_SOFT) && soft_strobe) ||
        ((cfg.clk_src == sss_pkg::CS_TIMER) && timer_ovf);

    // External mode counts edges, internal sources count strobes.
    always_comb begin
        step = sss_pkg::CNT_RST;
        if (samp_evt && out_evt) begin
            step = sss_pkg::CNT_TWO;
        end else if (samp_evt || out_evt || int_evt) begin
            step = sss_pkg::CNT_ONE;
        end
    end

    assign next_count = cnt_add(count, step);
    assign ovf_evt    = next_count[sss_pkg::CNT_W] && !cnt_wr;
    assign start_det  = two_wire && scl_sync && sda_prev && !di_sync;

    ////////////////////////////////////////////////////////////////////////

    // There is no receive buffer: a CPU write or the next shift replaces
    // the byte, so software must fetch it right after overflow.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_data_register <= sss_pkg::DATA_RST;
        end else if (data_wr) begin
            shift_data_register <= data_wdata;
        end else if (samp_evt) begin
            shift_data_register <=
                {shift_data_register[sss_pkg::MSB-1:0], samp_bit};
        end else if (int_evt) begin
            shift_data_register <=
                {shift_data_register[sss_pkg::MSB-1:0], di_sync};
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            count <= sss_pkg::CNT_RST;
        end else if (cnt_wr) begin
            count <= cnt_wdata;
        end else begin
            count <= next_count[sss_pkg::CNT_W-1:0];
        end
    end

    // With the external clock the output latch opens only on the edge opposite
    // sampling, so the partner never sees data move under its own sampling edge.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_latch <= 1'b0;
        end else if (data_wr) begin
            out_latch <= data_wdata[sss_pkg::MSB];
        end else if (out_evt || (!ext_mode && int_evt)) begin
            out_latch <= shift_data_register[sss_pkg::MSB];
        end
    end

    // A set in the same cycle as a clear wins.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags <= '0;
        end else begin
            flags.ovf   <= ovf_evt || (flags.ovf && !flag_clr.ovf);
            flags.start <= start_det ||
                (flags.start && !flag_clr.start);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sda_prev <= 1'b1;
        end else begin
            sda_prev <= di_sync;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq       <= '0;
            wake_idle <= 1'b0;
            wake_deep <= 1'b0;
        end else begin
            irq.ovf   <= flags.ovf && irq_en.ovf;
            irq.start <= flags.start && irq_en.start;
            wake_idle <= (flags.ovf && irq_en.ovf) ||
                (flags.start && irq_en.start);
            wake_deep <= two_wire && flags.start && irq_en.start;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    // One toggle per strobe, so software clocks at most at half sys_clk.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clk_level <= 1'b0;
        end else if (clock_toggle_strobe) begin
            clk_level <= ~clk_level;
        end
    end

    // The hold lasts until software clears the flag that caused it.
    assign hold_low = two_wire &&
        ((flags.start && cfg.hold_start) ||
         (flags.ovf && cfg.hold_ovf));

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            data_out_pin <= 1'b0;
            sda_out      <= 1'b0;
            sda_oe       <= 1'b0;
            scl_out      <= 1'b0;
            scl_oe       <= 1'b0;
        end else begin
            data_out_pin <= (cfg.wire_mode == sss_pkg::WM_THREE) &&
                out_latch;
            sda_out      <= 1'b0;
            sda_oe       <= two_wire && !out_latch;
            if (two_wire) begin
                scl_out <= 1'b0;
                scl_oe  <= hold_low || (cfg.clk_master && !clk_level);
            end else begin
                scl_out <= clk_level;
                scl_oe  <= cfg.clk_master &&
                    (cfg.wire_mode == sss_pkg::WM_THREE);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////

    sequence samp_seen;
        samp_evt && !data_wr && !out_evt;
    endsequence

    sequence msb_moves;
        out_evt && !data_wr ##1
            out_latch == $past(shift_data_register[sss_pkg::MSB]);
    endsequence

    cpu_write_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        data_wr |=> shift_data_register == $past(data_wdata))
        else $error("shift register missed a CPU write");

    shift_in_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        samp_seen |=> shift_data_register ==
            {$past(shift_data_register[sss_pkg::MSB-1:0]), $past(samp_bit)})
        else $error("sampled bit did not enter the LSB");

    latch_hold_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        samp_seen |=> $stable(out_latch))
        else $error("output latch moved on the sampling edge");

    latch_move_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        out_evt && !data_wr |-> msb_moves)
        else $error("output latch missed the shifting edge");

    out_pin_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        cfg.wire_mode == sss_pkg::WM_THREE ##1
            cfg.wire_mode == sss_pkg::WM_THREE
        |-> data_out_pin == $past(out_latch))
        else $error("three-wire pin does not follow the latch");

    ovf_set_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        count == sss_pkg::CNT_MAX && step == sss_pkg::CNT_ONE && !cnt_wr
        |=> flags.ovf && count == sss_pkg::CNT_RST)
        else $error("counter wrap did not set the overflow flag");

    ovf_sticky_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        flags.ovf && !flag_clr.ovf |=> flags.ovf)
        else $error("overflow flag dropped without a clear");

    start_flag_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        start_det |=> flags.start ##1 (irq.start == irq_en.start)[*1])
        else $error("start condition not flagged");

    hold_low_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        hold_low |=> scl_oe && !scl_out)
        else $error("clock line not held low");

    toggle_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        clock_toggle_strobe |=> clk_level != $past(clk_level))
        else $error("clock toggle strobe had no effect");

    wake_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        flags.ovf && irq_en.ovf |=> wake_idle)
        else $error("overflow did not request wake-up");

endmodule : sss_serial_shift_unit

// ### sss_spi_partner.sv
`timescale 1ns/1ns
module sss_spi_partner #(
    parameter int HALF_NS = 32
) (
    output logic      link_clk,
    output logic      data_line,
    input  wire logic device_out
);

    // The clock stands low between frames, as a software master leaves it.
    initial begin
        link_clk  = 1'b0;
        data_line = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic drive(input logic c, input logic d);
        link_clk  = c;
        data_line = d;
    endtask : drive

    // Late mode changes data after the rising edge and reads before the next.
    task automatic frame(input logic late, input logic [7:0] tx,
                         output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            if (!late) begin
                data_line = tx[i];
                #4;
                link_clk = 1'b1;
                #(HALF_NS - 1);
                rx[i] = device_out;
                #1;
                link_clk = 1'b0;
                #(HALF_NS - 4);
            end else begin
                link_clk = 1'b1;
                #4;
                data_line = tx[i];
                #(HALF_NS - 4);
                link_clk = 1'b0;
                #(HALF_NS - 1);
                rx[i] = device_out;
                #1;
            end
        end
        // Released line: show the inverse so a stale value is never trusted.
        data_line = ~data_line;
    endtask : frame

endmodule : sss_spi_partner

// ### sss_serial_shift_unit_tb.sv
`timescale 1ns/1ns
module sss_serial_shift_unit_tb;

    logic                       sys_clk;
    logic                       sys_rst;
    wire                        shift_clock_pin;
    wire                        serial_data_in;
    sss_pkg::sss_cfg_t          cfg;
    logic                       data_wr;
    logic [7:0]                 data_wdata;
    logic                       cnt_wr;
    logic [3:0]                 cnt_wdata;
    logic                       soft_strobe;
    logic                       timer_ovf;
    logic                       clock_toggle_strobe;
    sss_pkg::sss_evt_t          flag_clr;
    sss_pkg::sss_evt_t          irq_en;
    logic [7:0]                 shift_data_register;
    logic [3:0]                 count;
    sss_pkg::sss_evt_t          flags;
    sss_pkg::sss_evt_t          irq;
    logic                       wake_idle;
    logic                       wake_deep;
    logic                       data_out_pin;
    logic                       sda_out;
    logic                       sda_oe;
    logic                       scl_out;
    logic                       scl_oe;
    logic                       p_clk;
    logic                       p_data;
    logic                       two;
    logic [1:0]                 fl;
    int                         fail_count;
    int                         checks_done;

    // Open-drain lines in two-wire mode; the bus pull-ups make them wired-and.
    assign two = (cfg.wire_mode == sss_pkg::WM_TWO);
    assign shift_clock_pin = two ? (p_clk & ~(scl_oe & ~scl_out))
                                 : (scl_oe ? scl_out : p_clk);
    assign serial_data_in = two ? (p_data & ~(sda_oe & ~sda_out)) : p_data;
    assign fl = flags;

    sss_serial_shift_unit u_sss_serial_shift_unit (
        .sys_clk(sys_clk), .sys_rst(sys_rst),
        .shift_clock_pin(shift_clock_pin), .serial_data_in(serial_data_in),
        .cfg(cfg), .data_wr(data_wr), .data_wdata(data_wdata),
        .cnt_wr(cnt_wr), .cnt_wdata(cnt_wdata), .soft_strobe(soft_strobe),
        .timer_ovf(timer_ovf), .clock_toggle_strobe(clock_toggle_strobe),
        .flag_clr(flag_clr), .irq_en(irq_en),
        .shift_data_register(shift_data_register), .count(count),
        .flags(flags), .irq(irq), .wake_idle(wake_idle),
        .wake_deep(wake_deep), .data_out_pin(data_out_pin),
        .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out),
        .scl_oe(scl_oe)
    );

    sss_spi_partner u_sss_spi_partner (
        .link_clk(p_clk), .data_line(p_data), .device_out(data_out_pin)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        if (fail_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run

    task automatic wr(input logic which, input logic [7:0] d);
        @(negedge sys_clk);
        data_wdata = d;
        cnt_wdata  = d[3:0];
        data_wr    = !which;
        cnt_wr     = which;
        @(negedge sys_clk);
        data_wr = 1'b0;
        cnt_wr  = 1'b0;
    endtask : wr

    task automatic strobe(input int sel);
        @(negedge sys_clk);
        soft_strobe         = (sel == 0);
        timer_ovf           = (sel == 1);
        clock_toggle_strobe = (sel == 2);
        flag_clr            = (sel == 3) ? 2'b01 : (sel == 4) ? 2'b10 : 2'b00;
        @(negedge sys_clk);
        soft_strobe         = 1'b0;
        timer_ovf           = 1'b0;
        clock_toggle_strobe = 1'b0;
        flag_clr            = 2'b00;
    endtask : strobe

    task automatic wait_flag(input int sel);
        int n;
        n = 0;
        while (fl[sel] !== 1'b1 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        if (fl[sel] !== 1'b1) begin
            check({7'h0, fl[sel]}, 8'h01);
            complete_run();
        end
    endtask : wait_flag

    ////////////////////////////////////////////////////////////////////////
    task automatic test_cpu();
        check({2'h0, flags, irq, wake_idle, wake_deep}, 8'h00);
        check(shift_data_register, 8'h00);
        wr(1'b0, 8'hA5);
        check(shift_data_register, 8'hA5);
        @(negedge sys_clk);
        check({7'h0, data_out_pin}, 8'h01);
        wr(1'b0, 8'h5A);
        @(negedge sys_clk);
        check({7'h0, data_out_pin}, 8'h00);
        wr(1'b1, 8'h0A);
        check({4'h0, count}, 8'h0A);
    endtask : test_cpu

    task automatic test_internal();
        wr(1'b1, 8'h00);
        wr(1'b0, 8'h81);
        u_sss_spi_partner.drive(1'b0, 1'b1);
        repeat (3) @(negedge sys_clk);
        strobe(0);
        check(shift_data_register, 8'h03);
        check({4'h0, count}, 8'h01);
        strobe(1);
        check(shift_data_register, 8'h03);
        cfg.clk_src = sss_pkg::CS_TIMER;
        u_sss_spi_partner.drive(1'b0, 1'b0);
        repeat (3) @(negedge sys_clk);
        strobe(1);
        strobe(0);
        check(shift_data_register, 8'h06);
        check({4'h0, count}, 8'h02);
    endtask : test_internal

    task automatic test_overflow();
        cfg.clk_src = sss_pkg::CS_SOFT;
        irq_en      = 2'b01;
        wr(1'b1, 8'h0F);
        strobe(0);
        check({4'h0, count, 2'h0, flags}, 8'h01);
        repeat (2) @(negedge sys_clk);
        check({6'h0, irq.ovf, wake_idle}, 8'h03);
        strobe(0);
        check({7'h0, flags.ovf}, 8'h01);
        strobe(3);
        check({7'h0, flags.ovf}, 8'h00);
        irq_en = 2'b00;
    endtask : test_overflow

    // Both edge selections, each with the partner as master on the link.
    task automatic test_link();
        logic [7:0] dev [2];
        logic [7:0] mst [2];
        logic [7:0] rx;
        dev = '{8'h3C, 8'hA6};
        mst = '{8'hC5, 8'h59};
        for (int m = 0; m < 2; m++) begin
            @(negedge sys_clk);
            cfg.clk_src           = sss_pkg::CS_EXT;
            cfg.clock_edge_select = m[0];
            wr(1'b1, 8'h00);
            wr(1'b0, dev[m]);
            repeat (2) @(negedge sys_clk);
            u_sss_spi_partner.frame(m[0], mst[m], rx);
            wait_flag(0);
            check(shift_data_register, mst[m]);
            check({4'h0, count}, 8'h00);
            check(rx, dev[m]);
            strobe(3);
        end
    endtask : test_link

    task automatic test_toggle();
        cfg.clk_src    = sss_pkg::CS_SOFT;
        cfg.clk_master = 1'b1;
        strobe(2);
        @(negedge sys_clk);
        check({6'h0, scl_out, shift_clock_pin}, 8'h03);
        strobe(2);
        @(negedge sys_clk);
        check({7'h0, scl_out}, 8'h00);
        cfg.clk_master = 1'b0;
    endtask : test_toggle

    task automatic test_start();
        cfg = '{sss_pkg::WM_TWO, sss_pkg::CS_EXT, 1'b0, 1'b0, 1'b1, 1'b0};
        irq_en = 2'b10;
        wr(1'b0, 8'hFF);
        u_sss_spi_partner.drive(1'b1, 1'b1);
        repeat (8) @(negedge sys_clk);
        check({6'h0, flags.start, sda_oe}, 8'h00);
        u_sss_spi_partner.drive(1'b1, 1'b0);
        wait_flag(1);
        repeat (3) @(negedge sys_clk);
        check({6'h0, scl_oe, shift_clock_pin}, 8'h02);
        check({6'h0, irq.start, wake_deep}, 8'h03);
        strobe(4);
        repeat (2) @(negedge sys_clk);
        check({6'h0, scl_oe, flags.start}, 8'h00);
        u_sss_spi_partner.drive(1'b0, 1'b1);
        // A zero MSB pulls the data line low through the open drain.
        wr(1'b0, 8'h00);
        @(negedge sys_clk);
        check({5'h0, sda_out, sda_oe, serial_data_in}, 8'h02);
    endtask : test_start

    initial begin
        sys_rst     = 1'b1;
        cfg = '{sss_pkg::WM_THREE, sss_pkg::CS_SOFT, 1'b0, 1'b0, 1'b0, 1'b0};
        data_wr     = 1'b0;
        data_wdata  = 8'h00;
        cnt_wr      = 1'b0;
        cnt_wdata   = 4'h0;
        soft_strobe = 1'b0;
        timer_ovf   = 1'b0;
        clock_toggle_strobe = 1'b0;
        flag_clr    = 2'b00;
        irq_en      = 2'b00;
        fail_count  = 0;
        checks_done = 0;
        repeat (5) @(negedge sys_clk);
        sys_rst = 1'b0;
        test_cpu();
        test_internal();
        test_overflow();
        test_link();
        test_toggle();
        test_start();
        complete_run();
    end

endmodule : sss_serial_shift_unit_tb
